// ---- src/ndf_pkg.sv ----
// Purpose: Shared constants for the notch and damping filter select block
// Assumes: 20 MHz control clock, synchronous active-low reset
// Notes: Register offsets are word addresses on the plain register port
package ndf_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 20000000;
    localparam int CMD_WIN_NS = 125000; // Command pulse counting window, 0.125 ms
    localparam int CMD_WIN_CYC = (CMD_WIN_NS * (CLK_HZ / 1000000)) / 1000;
    localparam logic [12:0] CMD_WIN_LAST = 13'(CMD_WIN_CYC - 1);

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_N3_WIDTH = 4'h0;
    localparam logic [3:0] OFS_N3_DEPTH = 4'h1;
    localparam logic [3:0] OFS_N4_FREQ = 4'h2;
    localparam logic [3:0] OFS_N4_WIDTH = 4'h3;
    localparam logic [3:0] OFS_N4_DEPTH = 4'h4;
    localparam logic [3:0] OFS_SW_MODE = 4'h5;
    localparam logic [3:0] OFS_CTRL = 4'h6;
    localparam logic [3:0] OFS_DAMP_FREQ0 = 4'h8; // Four consecutive words
    localparam logic [3:0] OFS_STATUS = 4'hC;
    localparam logic [3:0] OFS_APPLY = 4'hD;

    // ==========================================================
    // Limits and reset values
    localparam logic [15:0] WIDTH_MAX = 16'h0014;
    localparam logic [15:0] WIDTH_RST = 16'h0002;
    localparam logic [15:0] DEPTH_MAX = 16'h0063;
    localparam logic [15:0] DEPTH_RST = 16'h0000;
    localparam logic [15:0] FREQ_MIN = 16'h0032;
    localparam logic [15:0] FREQ_MAX = 16'h1388;
    localparam logic [15:0] FREQ_RST = 16'h1388;
    localparam logic [15:0] MODE_MAX = 16'h0006;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] DFREQ_MAX = 16'h0BB8;
    localparam logic [15:0] DFREQ_MIN_VALID = 16'h000A; // 0..9 disable, unit 0.1 Hz
    localparam logic [15:0] DFREQ_RST = 16'h0000;

    // Control register fields
    localparam int CTRL_TWO_DOF = 0;
    localparam int CTRL_AD_LO = 1; // Adaptive mode, bits 3:1
    localparam int CTRL_AD_HI = 3;

    // Adaptive modes
    localparam logic [2:0] AD_ONE = 3'h1;
    localparam logic [2:0] AD_TWO = 3'h2;
    localparam logic [2:0] AD_PRECISE = 3'h5;

    // Selector states, one bit flips per step except IDLE to SWITCH
    typedef enum logic [1:0] {
        NDF_IDLE = 2'b00,
        NDF_CMD = 2'b01,
        NDF_SWITCH = 2'b11
    } ndf_sel_e;
endpackage

// ---- src/ndf_damp_map.sv ----
// Purpose: Maps switching mode and inputs to the damping enable vector
// Assumes: Inputs already synchronised to the control clock
// Notes: Purely combinational, sampled by the selector at a switch
module ndf_damp_map (
    input wire logic [2:0] i_mode,
    input wire logic i_sel_a,
    input wire logic i_sel_b,
    input wire logic i_dir_neg,
    input wire logic i_two_dof,
    output logic [3:0] o_enable
);
    // ==========================================================
    // Mode decode, bit0 is the first filter or model
    always_comb begin
        case (i_mode)
            3'h0: o_enable = 4'b0011;
            3'h1: o_enable = i_sel_a ? 4'b1010 : 4'b0101;
            3'h2: o_enable = 4'(4'b0001 << {i_sel_b, i_sel_a});
            3'h3: o_enable = i_dir_neg ? 4'b1010 : 4'b0101;
            3'h4: o_enable = i_two_dof ? 4'b0011 : 4'b0111;
            3'h5: o_enable = i_two_dof ? (i_sel_a ? 4'b0010 : 4'b0001) : 4'b0011;
            3'h6: o_enable = i_two_dof ? (i_dir_neg ? 4'b0010 : 4'b0001) : 4'b0011;
            default: o_enable = 4'b0011;
        endcase
    end
endmodule

// ---- src/ndf_notch_shape.sv ----
// Purpose: Turns notch width and depth settings into shaping coefficients
// Assumes: Settings are already clamped to their legal ranges
// Notes: Linear maps keep the coefficient monotonic in the setting
module ndf_notch_shape (
    input wire logic [4:0] i_width,
    input wire logic [6:0] i_depth,
    output logic [7:0] o_bw_coef,
    output logic [7:0] o_gain_coef
);
    // ==========================================================
    // wider with setting
    assign o_bw_coef = 8'({3'h0, i_width} * 8'h0C);
    assign o_gain_coef = 8'({1'b0, i_depth} + {2'h0, i_depth[6:1]});
endmodule

// ---- src/ndf_select.sv ----
// Purpose: Notch three/four settings and damping filter selection
// Assumes: One 20 MHz clock; command pulses arrive as one-cycle strobes
// Notes: Selection inputs and in-position come from pins, synchronised here
//
// The address-and-strobe port and the placing of the registers were left to the implementer.

// Operation
// - Third notch width 0..20, default 2
// - Third notch depth defaults to 0
// - Fourth notch frequency 50..5000, 5000 disables
// - Adaptive loads fourth frequency from estimate
// - Fourth notch width 0..20, default 2
// - Fourth notch depth 0..99, default 0
// - Width grows notch monotonically
// - Depth setting makes notch shallower
// - Adaptive overwrites third/fourth notch parameters
// - Switching mode 0..6 default 0
// - Mode 0 enables filters one and two
// - Mode 1 pair by input a
// - Mode 2 single filter by b,a
// - Mode 3 pair by command direction
// - No 2DOF: mode 4 models 1-3
// - 2DOF modes 4..6 pick models
// - Switch at qualified command edge in position
// - Release stored difference faster at switch
// - Power-cycle parameters apply at next power-on
// - Adaptive 1 third only, 2 both
// - Damping frequency 0..9 disables filter
module ndf_select (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_sel_a,
    input wire logic i_sel_b,
    input wire logic i_in_position,
    input wire logic i_cmd_pulse,
    input wire logic i_cmd_neg,
    input wire logic i_ad_valid,
    input wire logic [15:0] i_ad_freq2,
    input wire logic [4:0] i_ad_width3,
    input wire logic [6:0] i_ad_depth3,
    input wire logic [4:0] i_ad_width4,
    input wire logic [6:0] i_ad_depth4,
    output logic [3:0] o_damp_enable,
    output logic o_damp_switch,
    output logic o_fast_release,
    output logic [15:0] o_n4_freq,
    output logic o_n4_active,
    output logic [7:0] o_n3_bw,
    output logic [7:0] o_n3_gain,
    output logic [7:0] o_n4_bw,
    output logic [7:0] o_n4_gain
);
    // ==========================================================
    // Helpers

    // Saturates a written value into [lo, hi]
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // True when an adaptive mode owns the given notch (0 third, 1 fourth)
    function automatic logic ad_owns(input logic [2:0] m, input logic fourth);
        if (fourth) begin
            ad_owns = (m == ndf_pkg::AD_TWO) || (m == ndf_pkg::AD_PRECISE);
        end else begin
            ad_owns = (m == ndf_pkg::AD_ONE) || (m == ndf_pkg::AD_TWO) ||
                      (m == ndf_pkg::AD_PRECISE);
        end
    endfunction

    // ==========================================================
    // Declarations
    logic [15:0] n3_width_reg;
    logic [15:0] n3_depth_reg;
    logic [15:0] n4_freq_reg;
    logic [15:0] n4_width_reg;
    logic [15:0] n4_depth_reg;
    logic [15:0] mode_pend_reg;
    logic [15:0] mode_live_reg;
    logic [3:0] ctrl_pend_reg;
    logic [3:0] ctrl_live_reg;
    logic [15:0] dfreq_reg [0:3];
    logic [1:0] sa_sync_reg;
    logic [1:0] sb_sync_reg;
    logic [1:0] ip_sync_reg;
    logic [12:0] win_cnt_reg;
    logic win_busy_reg;
    logic win_prev_busy_reg;
    logic cmd_dir_reg;
    ndf_pkg::ndf_sel_e state_reg;
    ndf_pkg::ndf_sel_e state_next;
    logic [3:0] enable_reg;
    logic [3:0] map_enable;
    logic [3:0] dfreq_ok;
    logic switch_now;
    logic wr_hit;
    logic [2:0] ad_mode;
    logic [7:0] n3_bw;
    logic [7:0] n3_gain;
    logic [7:0] n4_bw;
    logic [7:0] n4_gain;

    assign ad_mode = ctrl_live_reg[ndf_pkg::CTRL_AD_HI:ndf_pkg::CTRL_AD_LO];
    assign wr_hit = i_wr;

    // ==========================================================
    // Pin synchronisers, first stage read only by second
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sa_sync_reg <= 2'h0;
            sb_sync_reg <= 2'h0;
            ip_sync_reg <= 2'h0;
        end else begin
            sa_sync_reg <= {sa_sync_reg[0], i_sel_a};
            sb_sync_reg <= {sb_sync_reg[0], i_sel_b};
            ip_sync_reg <= {ip_sync_reg[0], i_in_position};
        end
    end

    // ==========================================================
    // Third notch settings; writes clamped, adaptive overrides
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            n3_width_reg <= ndf_pkg::WIDTH_RST;
            n3_depth_reg <= ndf_pkg::DEPTH_RST;
        end else if (i_ad_valid && ad_owns(ad_mode, 1'b0)) begin
            n3_width_reg <= {11'h000, i_ad_width3};
            n3_depth_reg <= {9'h000, i_ad_depth3};
        end else if (wr_hit) begin
            if (i_addr == ndf_pkg::OFS_N3_WIDTH) begin
                n3_width_reg <= clamp(i_wdata, 16'h0000, ndf_pkg::WIDTH_MAX);
            end
            if (i_addr == ndf_pkg::OFS_N3_DEPTH) begin
                n3_depth_reg <= clamp(i_wdata, 16'h0000, ndf_pkg::DEPTH_MAX);
            end
        end
    end

    // ==========================================================
    // Fourth notch settings
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            n4_freq_reg <= ndf_pkg::FREQ_RST;
            n4_width_reg <= ndf_pkg::WIDTH_RST;
            n4_depth_reg <= ndf_pkg::DEPTH_RST;
        end else if (i_ad_valid && ad_owns(ad_mode, 1'b1)) begin
            n4_freq_reg <= clamp(i_ad_freq2, ndf_pkg::FREQ_MIN, ndf_pkg::FREQ_MAX);
            n4_width_reg <= {11'h000, i_ad_width4};
            n4_depth_reg <= {9'h000, i_ad_depth4};
        end else if (wr_hit) begin
            if (i_addr == ndf_pkg::OFS_N4_FREQ) begin
                n4_freq_reg <= clamp(i_wdata, ndf_pkg::FREQ_MIN, ndf_pkg::FREQ_MAX);
            end
            if (i_addr == ndf_pkg::OFS_N4_WIDTH) begin
                n4_width_reg <= clamp(i_wdata, 16'h0000, ndf_pkg::WIDTH_MAX);
            end
            if (i_addr == ndf_pkg::OFS_N4_DEPTH) begin
                n4_depth_reg <= clamp(i_wdata, 16'h0000, ndf_pkg::DEPTH_MAX);
            end
        end
    end

    // ==========================================================
    // Mode and control: written to a pending copy, made live only by
    // the apply strobe, which stands in for the next control power-on
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_pend_reg <= ndf_pkg::MODE_RST;
            ctrl_pend_reg <= 4'h0;
        end else if (wr_hit) begin
            if (i_addr == ndf_pkg::OFS_SW_MODE) begin
                mode_pend_reg <= clamp(i_wdata, 16'h0000, ndf_pkg::MODE_MAX);
            end
            if (i_addr == ndf_pkg::OFS_CTRL) begin
                ctrl_pend_reg <= i_wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_live_reg <= ndf_pkg::MODE_RST;
            ctrl_live_reg <= 4'h0;
        end else if (wr_hit && i_addr == ndf_pkg::OFS_APPLY) begin
            mode_live_reg <= mode_pend_reg;
            ctrl_live_reg <= ctrl_pend_reg;
        end
    end

    // ==========================================================
    // Damping frequencies, one word each
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 4; i++) begin
                dfreq_reg[i] <= ndf_pkg::DFREQ_RST;
            end
        end else if (wr_hit && i_addr[3:2] == ndf_pkg::OFS_DAMP_FREQ0[3:2]) begin
            dfreq_reg[i_addr[1:0]] <= clamp(i_wdata, 16'h0000, ndf_pkg::DFREQ_MAX);
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dfreq_ok[i] = (dfreq_reg[i] >= ndf_pkg::DFREQ_MIN_VALID);
        end
    end

    // ==========================================================
    // Command window: busy while any pulse seen in the last 0.125 ms
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            win_cnt_reg <= 13'h0000;
            win_busy_reg <= 1'b0;
            win_prev_busy_reg <= 1'b0;
            cmd_dir_reg <= 1'b0;
        end else begin
            win_prev_busy_reg <= win_busy_reg;
            if (i_cmd_pulse) begin
                win_cnt_reg <= ndf_pkg::CMD_WIN_LAST;
                win_busy_reg <= 1'b1;
                cmd_dir_reg <= i_cmd_neg;
            end else if (win_cnt_reg != 13'h0000) begin
                win_cnt_reg <= win_cnt_reg - 13'h0001;
            end else begin
                win_busy_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Selection map
    ndf_damp_map u_map (
        .i_mode(mode_live_reg[2:0]),
        .i_sel_a(sa_sync_reg[1]),
        .i_sel_b(sb_sync_reg[1]),
        .i_dir_neg(cmd_dir_reg),
        .i_two_dof(ctrl_live_reg[ndf_pkg::CTRL_TWO_DOF]),
        .o_enable(map_enable)
    );

    assign switch_now = win_busy_reg && !win_prev_busy_reg && ip_sync_reg[1];

    // Selector state machine
    always_comb begin
        case (state_reg)
            ndf_pkg::NDF_IDLE: state_next = switch_now ? ndf_pkg::NDF_SWITCH : ndf_pkg::NDF_IDLE;
            ndf_pkg::NDF_SWITCH: state_next = ndf_pkg::NDF_CMD;
            ndf_pkg::NDF_CMD: state_next = win_busy_reg ? ndf_pkg::NDF_CMD : ndf_pkg::NDF_IDLE;
            default: state_next = ndf_pkg::NDF_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= ndf_pkg::NDF_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            enable_reg <= 4'b0011;
        end else if (switch_now) begin
            enable_reg <= map_enable;
        end
    end

    // ==========================================================
    // Notch shaping
    ndf_notch_shape u_n3 (
        .i_width(n3_width_reg[4:0]),
        .i_depth(n3_depth_reg[6:0]),
        .o_bw_coef(n3_bw),
        .o_gain_coef(n3_gain)
    );

    ndf_notch_shape u_n4 (
        .i_width(n4_width_reg[4:0]),
        .i_depth(n4_depth_reg[6:0]),
        .o_bw_coef(n4_bw),
        .o_gain_coef(n4_gain)
    );

    // ==========================================================
    // Registered outputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_damp_enable <= 4'h0;
            o_damp_switch <= 1'b0;
            o_fast_release <= 1'b0;
            o_n4_freq <= ndf_pkg::FREQ_RST;
            o_n4_active <= 1'b0;
            o_n3_bw <= 8'h00;
            o_n3_gain <= 8'h00;
            o_n4_bw <= 8'h00;
            o_n4_gain <= 8'h00;
        end else begin
            o_damp_enable <= enable_reg & dfreq_ok;
            o_damp_switch <= (state_reg == ndf_pkg::NDF_SWITCH);
            o_fast_release <= (state_reg == ndf_pkg::NDF_SWITCH) ||
                              (o_fast_release && state_reg == ndf_pkg::NDF_CMD);
            o_n4_freq <= n4_freq_reg;
            o_n4_active <= (n4_freq_reg != ndf_pkg::FREQ_MAX);
            o_n3_bw <= n3_bw;
            o_n3_gain <= n3_gain;
            o_n4_bw <= n4_bw;
            o_n4_gain <= n4_gain;
        end
    end

    // ==========================================================
    // Read port, data one cycle after strobe; unmapped reads zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                ndf_pkg::OFS_N3_WIDTH: o_rdata <= n3_width_reg;
                ndf_pkg::OFS_N3_DEPTH: o_rdata <= n3_depth_reg;
                ndf_pkg::OFS_N4_FREQ: o_rdata <= n4_freq_reg;
                ndf_pkg::OFS_N4_WIDTH: o_rdata <= n4_width_reg;
                ndf_pkg::OFS_N4_DEPTH: o_rdata <= n4_depth_reg;
                ndf_pkg::OFS_SW_MODE: o_rdata <= mode_pend_reg;
                ndf_pkg::OFS_CTRL: o_rdata <= {12'h000, ctrl_pend_reg};
                4'h8, 4'h9, 4'hA, 4'hB: o_rdata <= dfreq_reg[i_addr[1:0]];
                ndf_pkg::OFS_STATUS: o_rdata <= {8'h00, mode_live_reg[2:0],
                                                 ip_sync_reg[1], enable_reg};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule

// ---- bench/ndf_select_sva.sv ----
// Purpose: Port-level checks for the notch and damping select block
// Assumes: One clock, synchronous active-low reset, host spaces its strobes
// Notes: The quiet count saturates well past the window to stay off its edge
module ndf_select_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_in_position,
    input wire logic i_cmd_pulse,
    input wire logic i_ad_valid,
    input wire logic [15:0] o_rdata,
    input wire logic [3:0] o_damp_enable,
    input wire logic o_damp_switch,
    input wire logic o_fast_release,
    input wire logic [15:0] o_n4_freq,
    input wire logic o_n4_active,
    input wire logic [7:0] o_n3_bw,
    input wire logic [7:0] o_n4_gain
);
    // ==========================================================
    // Helper: cycles since the last command pulse
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [12:0] idle_cnt;
    // Starts saturated, as the window is idle after reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            idle_cnt <= 13'h0BB8;
        end else if (i_cmd_pulse) begin
            idle_cnt <= 13'h0000;
        end else if (idle_cnt != 13'h0BB8) begin
            idle_cnt <= idle_cnt + 13'h0001;
        end
    end
    // ==========================================================
    // Sequences and assertions
    sequence s_qual_cmd;
        i_cmd_pulse && idle_cnt == 13'h0BB8 && $past(i_in_position)
            && $past(i_in_position, 2) && $past(i_in_position, 3);
    endsequence
    sequence s_one_pulse;
        o_damp_switch ##1 !o_damp_switch;
    endsequence
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero");
    a_n4_write: assert property (
        i_wr && i_addr == 4'h2 && !i_ad_valid && i_wdata >= 16'h0032 && i_wdata <= 16'h1388
        |-> ##2 o_n4_freq == $past(i_wdata, 2) && o_n4_active == ($past(i_wdata, 2) != 16'h1388))
        else $error("fourth freq wrong");
    a_width_clamp: assert property (
        i_wr && i_addr == 4'h0 && i_wdata > 16'h0014 && !i_ad_valid |-> ##2 o_n3_bw == 8'hF0)
        else $error("third width not clamped");
    a_gain_map: assert property (
        i_wr && i_addr == 4'h4 && i_wdata <= 16'h0063 && !i_ad_valid
        |-> ##2 o_n4_gain == 8'($past(i_wdata, 2) + ($past(i_wdata, 2) >> 1)))
        else $error("fourth depth gain wrong");
    a_switch_taken: assert property (s_qual_cmd |-> ##3 s_one_pulse)
        else $error("qualified command not switched");
    a_busy_ignored: assert property (
        i_cmd_pulse && idle_cnt < 13'h0960 |-> ##3 !o_damp_switch)
        else $error("switch inside busy window");
    a_inpos_needed: assert property (
        i_cmd_pulse && !$past(i_in_position) && !$past(i_in_position, 2) |-> ##3 !o_damp_switch)
        else $error("switch while not in position");
    a_switch_cause: assert property (o_damp_switch |-> $past(i_cmd_pulse, 3))
        else $error("switch without command");
    a_release_with: assert property (o_damp_switch |-> o_fast_release)
        else $error("fast release missing at switch");
    a_release_end: assert property (
        $fell(o_fast_release) |-> idle_cnt >= 13'h09B0 && idle_cnt <= 13'h09D8)
        else $error("fast release end misplaced");
    a_enable_hold: assert property (
        $changed(o_damp_enable) && !$past(i_wr) && !$past(i_wr, 2) |-> o_damp_switch)
        else $error("enable changed without switch");
endmodule

// Checker ports carry the same names as the block's ports
bind ndf_select ndf_select_chk chk (.*);

// ---- bench/ndf_host.sv ----
// Purpose: Host model driving command pulses, select and in-position lines
// Assumes: Bench calls its tasks; all changes land just after a rising edge
// Notes: Direction inverts between pulses to expose late sampling
module ndf_host (
    input wire logic i_clk,
    output logic o_cmd_pulse,
    output logic o_cmd_neg,
    output logic o_sel_a,
    output logic o_sel_b,
    output logic o_in_pos
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Idle levels
    initial begin
        o_cmd_pulse = 1'b0;
        o_cmd_neg = 1'b0;
        o_sel_a = 1'b0;
        o_sel_b = 1'b0;
        o_in_pos = 1'b0;
    end
    // Select and in-position are levels held until changed
    task automatic set_lines(input logic a, input logic b, input logic ip);
        @(posedge i_clk);
        o_sel_a <= a;
        o_sel_b <= b;
        o_in_pos <= ip;
    endtask
    // One command pulse with its direction
    task automatic pulse(input logic neg);
        @(posedge i_clk);
        o_cmd_pulse <= 1'b1;
        o_cmd_neg <= neg;
        @(posedge i_clk);
        o_cmd_pulse <= 1'b0;
        o_cmd_neg <= ~neg;
    endtask
endmodule

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the notch and damping select block
// Assumes: 20 MHz clock, reset held five cycles
// Notes: Each switch waits out the quiet window
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst_n, i_wr, i_rd, i_ad_valid;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, i_ad_freq2, o_rdata, o_n4_freq;
    logic [4:0] i_ad_width3, i_ad_width4;
    logic [6:0] i_ad_depth3, i_ad_depth4;
    logic i_sel_a, i_sel_b, i_in_position, i_cmd_pulse, i_cmd_neg;
    logic [3:0] o_damp_enable;
    logic o_damp_switch, o_fast_release, o_n4_active;
    logic [7:0] o_n3_bw, o_n3_gain, o_n4_bw, o_n4_gain;
    int err_total = 0;
    int cmp_count = 0;
    // ==========================================================
    // Clock, host and design
    always #25 i_clk = ~i_clk;
    ndf_host hm (.i_clk(i_clk), .o_cmd_pulse(i_cmd_pulse), .o_cmd_neg(i_cmd_neg),
        .o_sel_a(i_sel_a), .o_sel_b(i_sel_b), .o_in_pos(i_in_position));
    ndf_select DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sel_a(i_sel_a), .i_sel_b(i_sel_b),
        .i_in_position(i_in_position), .i_cmd_pulse(i_cmd_pulse), .i_cmd_neg(i_cmd_neg),
        .i_ad_valid(i_ad_valid), .i_ad_freq2(i_ad_freq2), .i_ad_width3(i_ad_width3),
        .i_ad_depth3(i_ad_depth3), .i_ad_width4(i_ad_width4), .i_ad_depth4(i_ad_depth4),
        .o_damp_enable(o_damp_enable), .o_damp_switch(o_damp_switch),
        .o_fast_release(o_fast_release), .o_n4_freq(o_n4_freq), .o_n4_active(o_n4_active),
        .o_n3_bw(o_n3_bw), .o_n3_gain(o_n3_gain), .o_n4_bw(o_n4_bw), .o_n4_gain(o_n4_gain));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stands only in the slot after the strobe
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic echk(input logic [3:0] e);
        repeat (3) @(posedge i_clk);
        #1 chk(16'(o_damp_enable), 16'(e));
    endtask
    // Idle long enough that the next pulse opens a fresh window
    task automatic idle;
        repeat (ndf_pkg::CMD_WIN_CYC + 600) @(posedge i_clk);
    endtask
    // Code digits: mode, two-dof, b, a, negative, expected enables
    task automatic sw_case(input logic [23:0] c);
        wr(4'h5, 16'(c[22:20]));
        wr(4'h6, 16'(c[16]));
        wr(4'hD, 16'h0001);
        hm.set_lines(c[8], c[12], 1'b1);
        idle();
        chk(16'(o_fast_release), 16'h0000);
        hm.pulse(c[4]);
        echk(c[3:0]);
        chk(16'(o_fast_release), 16'h0001);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_defaults;
        chk(o_n4_freq, 16'h1388);
        chk(16'(o_n4_active), 16'h0000);
        chk(16'(o_n3_bw), 16'h0018);
        rchk(4'h0, 16'h0002);
        rchk(4'h1, 16'h0000);
        rchk(4'h2, 16'h1388);
        rchk(4'h3, 16'h0002);
        rchk(4'h4, 16'h0000);
        rchk(4'h5, 16'h0000);
        rchk(4'h7, 16'h0000);
        rchk(4'hB, 16'h0000);
        chk(16'(o_damp_enable), 16'h0000);
    endtask
    task automatic t_limits;
        wr(4'h0, 16'h0019);
        rchk(4'h0, 16'h0014);
        wr(4'h3, 16'h0019);
        rchk(4'h3, 16'h0014);
        chk(16'(o_n4_bw), 16'h00F0);
        wr(4'h4, 16'h0078);
        rchk(4'h4, 16'h0063);
        chk(16'(o_n4_gain), 16'h0094);
        wr(4'h1, 16'h000A);
        rchk(4'h1, 16'h000A);
        chk(16'(o_n3_gain), 16'h000F);
        wr(4'h4, 16'h000A);
        wr(4'h2, 16'h000A);
        rchk(4'h2, 16'h0032);
        wr(4'h2, 16'h0064);
        rchk(4'h2, 16'h0064);
        chk(16'(o_n4_active), 16'h0001);
        wr(4'h2, 16'h1388);
        rchk(4'h2, 16'h1388);
        chk(16'(o_n4_active), 16'h0000);
        wr(4'h5, 16'h0007);
        rchk(4'h5, 16'h0006);
    endtask
    task automatic t_map;
        for (int k = 0; k < 4; k++) begin
            wr(4'(8 + k), 16'h0064);
        end
        sw_case(24'h001103);
        sw_case(24'h101005);
        sw_case(24'h10010A);
        sw_case(24'h200001);
        sw_case(24'h200102);
        sw_case(24'h201004);
        sw_case(24'h201108);
        sw_case(24'h301105);
        sw_case(24'h30001A);
        sw_case(24'h400007);
        sw_case(24'h500103);
        sw_case(24'h600013);
        sw_case(24'h410003);
        sw_case(24'h510001);
        sw_case(24'h510102);
        sw_case(24'h610001);
        sw_case(24'h610012);
    endtask
    task automatic t_hold;
        wr(4'h5, 16'h0000);
        idle();
        hm.pulse(1'b0);
        echk(4'h1);
        wr(4'hD, 16'h0001);
        hm.pulse(1'b0);
        echk(4'h1);
        hm.set_lines(1'b1, 1'b1, 1'b0);
        idle();
        hm.pulse(1'b0);
        echk(4'h1);
        hm.set_lines(1'b1, 1'b1, 1'b1);
        idle();
        hm.pulse(1'b0);
        echk(4'h3);
        wr(4'h8, 16'h0009);
        echk(4'h2);
        wr(4'h8, 16'h000A);
        echk(4'h3);
    endtask
    task automatic t_adapt;
        wr(4'h6, 16'h0004);
        wr(4'hD, 16'h0001);
        i_ad_valid <= 1'b1;
        wr(4'h2, 16'h03E8);
        rchk(4'h2, 16'h012C);
        chk(o_n4_freq, 16'h012C);
        rchk(4'h0, 16'h0007);
        rchk(4'h4, 16'h000D);
        wr(4'h6, 16'h0002);
        wr(4'hD, 16'h0001);
        i_ad_freq2 <= 16'h0190;
        i_ad_width3 <= 5'h03;
        rchk(4'h2, 16'h012C);
        rchk(4'h0, 16'h0003);
        i_ad_valid <= 1'b0;
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        i_rst_n = 1'b0;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_ad_valid = 1'b0;
        i_ad_freq2 = 16'h012C;
        i_ad_width3 = 5'h07;
        i_ad_depth3 = 7'h0B;
        i_ad_width4 = 5'h09;
        i_ad_depth4 = 7'h0D;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1 t_defaults();
        t_limits();
        t_map();
        t_hold();
        t_adapt();
        results();
    end
    initial begin
        #4500000;
        err_total++;
        results();
    end
endmodule
